// ===== hdl/psof_defines.vh
// Purpose: Constants for the exchange-side protection switch-over engine
// Assumes: 50 MHz system clock
// Notes: Message and primitive codes are local encodings
`ifndef PSOF_DEFINES_VH
`define PSOF_DEFINES_VH

// Message type codes on the link side
`define PSOF_MSG_W 3
`define PSOF_MSG_NONE 3'h0
`define PSOF_MSG_COM 3'h1
`define PSOF_MSG_OS_COM 3'h2
`define PSOF_MSG_REQ 3'h3
`define PSOF_MSG_ACK 3'h4
`define PSOF_MSG_REJECT 3'h5

// Indication codes towards management
`define PSOF_IND_W 3
`define PSOF_IND_NONE 3'h0
`define PSOF_IND_REQ 3'h1
`define PSOF_IND_ACK 3'h2
`define PSOF_IND_REJECT 3'h3
`define PSOF_IND_ERROR 3'h4
`define PSOF_IND_REFUSED 3'h5

// Protection group allowed for pre-empting switch-over
`define PSOF_OS_GROUP 2'h2

// Timer durations in milliseconds, and clock rate
`define PSOF_CLK_HZ 50000000
`define PSOF_STD_TIMER_MS 1500
`define PSOF_OS_TIMER_MS 1500
// Timer loads in clock cycles, 1500 ms at the clock rate above
`define PSOF_STD_TIMER_CYC 27'h47868C0
`define PSOF_OS_TIMER_CYC 27'h47868C0

`endif

// ===== hdl/psof_exchange.v
// Purpose: Exchange-side protection switch-over protocol engine
// Assumes: Far end answers with well-formed ACK, REJECT or REQ messages
// Notes: Messages and primitives are one-cycle strobes with codes
// Contract
// RULE_01: Idle or peer-requested, operator command sends OS COM, starts timer, initiated.
// RULE_02: Operator pre-empting switch-over used only for protection group two.
// RULE_03: Operator command carries logical channel and target physical channel.
// RULE_04: Access side idle on OS COM enters initiated, tells management.
// RULE_05: Access management acknowledge makes access side send ACK, go idle.
// RULE_06: Initiated state ACK signals acknowledge, stops operator timer, idle.
// RULE_07: Initiated state discards REQ and keeps its switch-over going.
// RULE_08: Access management reject makes access side send REJECT with cause.
// RULE_09: Access side never rejects OS COM for occupied target channel.
// RULE_10: REJECT during operator procedure signals reject, stops timer, idle.
// RULE_11: First operator timer expiry resends OS COM and restarts timer.
// RULE_12: Second operator timer expiry signals error and returns idle.
// RULE_13: Idle state ACK still passed to management as acknowledge.
// RULE_14: Idle state REJECT still passed to management as reject.
// RULE_15: Operator timer expiry outside initiated state does nothing.
// RULE_16: Access side idle on request primitive sends REQ, starts timer.
// RULE_17: Operator request may name standby channel; autonomous request names none.
// RULE_18: No preference means link and time slot fields all zero.
// RULE_19: Idle on REQ enters peer-requested and passes request to management.
// RULE_20: Granted request sends COM, enters initiated, starts standard timer.
// RULE_21: Access requested state on any command enters initiated, stops timer.
// RULE_22: After grant, ACK signals acknowledge, stops standard timer, idle.
// RULE_23: Timer durations configurable; expiry counter set on retry, cleared on stop.
`timescale 1ns/100ps
`include "psof_defines.vh"

module psof_exchange #(
    parameter LCH_W = 16,
    parameter PCH_W = 13,
    parameter CNT_W = 27,
    parameter [26:0] STD_TIMER_CYC = `PSOF_STD_TIMER_CYC,
    parameter [26:0] OS_TIMER_CYC = `PSOF_OS_TIMER_CYC
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Management primitives in
    input wire mgmt_os_com,
    input wire mgmt_com,
    input wire mgmt_reject,
    input wire [1:0] mgmt_group,
    input wire [LCH_W-1:0] mgmt_lch,
    input wire [PCH_W-1:0] mgmt_pch,
    // Management indications out
    output reg ind_valid_q,
    output reg [`PSOF_IND_W-1:0] ind_code_q,
    output reg [2:0] state_q,
    // Messages received from the access side
    input wire rx_valid,
    input wire [`PSOF_MSG_W-1:0] rx_type,
    // Messages sent to the access side
    output reg tx_valid_q,
    output reg [`PSOF_MSG_W-1:0] tx_type_q,
    output reg [LCH_W-1:0] tx_lch_q,
    output reg [PCH_W-1:0] tx_pch_q
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [2:0] EXCHANGE_IDLE_STATE = 3'h1;
localparam [2:0] EXCHANGE_INITIATED_STATE = 3'h2;
localparam [2:0] EXCHANGE_PEER_REQUESTED_STATE = 3'h4;

reg os_proc_q;
reg std_start, std_stop, os_start, os_stop;
wire std_exp, std_once;
wire os_exp, os_once;

// ----------------------------------------
// Timers
// ----------------------------------------
// RULE_23: configurable durations
psof_timer #(.CNT_W(CNT_W), .LOAD(STD_TIMER_CYC)) u_standard_command_timer (
    .clk(clk),
    .nrst(nrst),
    .start(std_start),
    .stop(std_stop),
    .running_q(),
    .expire_q(std_exp),
    .expired_once_q(std_once)
);

psof_timer #(.CNT_W(CNT_W), .LOAD(OS_TIMER_CYC)) u_operator_command_timer (
    .clk(clk),
    .nrst(nrst),
    .start(os_start),
    .stop(os_stop),
    .running_q(),
    .expire_q(os_exp),
    .expired_once_q(os_once)
);

wire rx_ack = rx_valid && rx_type == `PSOF_MSG_ACK;
wire rx_rej = rx_valid && rx_type == `PSOF_MSG_REJECT;
wire rx_req = rx_valid && rx_type == `PSOF_MSG_REQ;
wire idle_or_peer = state_q == EXCHANGE_IDLE_STATE || state_q == EXCHANGE_PEER_REQUESTED_STATE;
wire in_init = state_q == EXCHANGE_INITIATED_STATE;
wire cur_exp = os_proc_q ? os_exp : std_exp;
wire cur_once = os_proc_q ? os_once : std_once;

// ----------------------------------------
// Timer control
// ----------------------------------------
always @* begin
    std_start = 1'b0;
    std_stop = 1'b0;
    os_start = 1'b0;
    os_stop = 1'b0;
    if (idle_or_peer && mgmt_os_com && mgmt_group == `PSOF_OS_GROUP) begin
        // RULE_01: start operator timer
        os_start = 1'b1;
        std_stop = 1'b1;
    end else if (state_q == EXCHANGE_PEER_REQUESTED_STATE && mgmt_com && !mgmt_os_com) begin
        // RULE_20: start standard timer
        std_start = 1'b1;
    end else if (in_init && (rx_ack || rx_rej)) begin
        // RULE_06: stop running timer
        os_stop = os_proc_q;
        std_stop = !os_proc_q;
    end else if (in_init && cur_exp) begin
        // RULE_11: restart on first expiry
        os_start = os_proc_q && !cur_once;
        std_start = !os_proc_q && !cur_once;
        os_stop = os_proc_q && cur_once;
        std_stop = !os_proc_q && cur_once;
    end
end

// ----------------------------------------
// Protocol state machine
// ----------------------------------------
always @(posedge clk) begin
    if (!nrst) begin
        state_q <= EXCHANGE_IDLE_STATE;
        os_proc_q <= 1'b0;
        ind_valid_q <= 1'b0;
        ind_code_q <= `PSOF_IND_NONE;
        tx_valid_q <= 1'b0;
        tx_type_q <= `PSOF_MSG_NONE;
        tx_lch_q <= {LCH_W{1'b0}};
        tx_pch_q <= {PCH_W{1'b0}};
    end else begin
        ind_valid_q <= 1'b0;
        tx_valid_q <= 1'b0;
        case (state_q)
            EXCHANGE_IDLE_STATE, EXCHANGE_PEER_REQUESTED_STATE: begin
                if (mgmt_os_com) begin
                    // RULE_02: group two only
                    if (mgmt_group == `PSOF_OS_GROUP) begin
                        // RULE_01: send OS COM
                        // RULE_03: logical and target channel
                        tx_valid_q <= 1'b1;
                        tx_type_q <= `PSOF_MSG_OS_COM;
                        tx_lch_q <= mgmt_lch;
                        tx_pch_q <= mgmt_pch;
                        os_proc_q <= 1'b1;
                        state_q <= EXCHANGE_INITIATED_STATE;
                    end else begin
                        ind_valid_q <= 1'b1;
                        ind_code_q <= `PSOF_IND_REFUSED;
                    end
                end else if (state_q == EXCHANGE_PEER_REQUESTED_STATE && mgmt_com) begin
                    // RULE_20: grant with COM
                    tx_valid_q <= 1'b1;
                    tx_type_q <= `PSOF_MSG_COM;
                    tx_lch_q <= mgmt_lch;
                    tx_pch_q <= mgmt_pch;
                    os_proc_q <= 1'b0;
                    state_q <= EXCHANGE_INITIATED_STATE;
                end else if (state_q == EXCHANGE_PEER_REQUESTED_STATE && mgmt_reject) begin
                    // RULE_20: reject the request
                    tx_valid_q <= 1'b1;
                    tx_type_q <= `PSOF_MSG_REJECT;
                    tx_lch_q <= mgmt_lch;
                    tx_pch_q <= mgmt_pch;
                    state_q <= EXCHANGE_IDLE_STATE;
                end else if (state_q == EXCHANGE_IDLE_STATE && rx_req) begin
                    // RULE_19: enter peer-requested
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_REQ;
                    state_q <= EXCHANGE_PEER_REQUESTED_STATE;
                end else if (state_q == EXCHANGE_IDLE_STATE && rx_ack) begin
                    // RULE_13: late ACK passed on
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_ACK;
                end else if (state_q == EXCHANGE_IDLE_STATE && rx_rej) begin
                    // RULE_14: late REJECT passed on
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_REJECT;
                end
                // RULE_15: stray expiry ignored
            end
            EXCHANGE_INITIATED_STATE: begin
                if (rx_ack) begin
                    // RULE_06: acknowledge and idle
                    // RULE_22: same for granted request
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_ACK;
                    state_q <= EXCHANGE_IDLE_STATE;
                end else if (rx_rej) begin
                    // RULE_10: reject and idle
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_REJECT;
                    state_q <= EXCHANGE_IDLE_STATE;
                end else if (cur_exp && !cur_once) begin
                    // RULE_11: resend command
                    tx_valid_q <= 1'b1;
                end else if (cur_exp) begin
                    // RULE_12: error and idle
                    ind_valid_q <= 1'b1;
                    ind_code_q <= `PSOF_IND_ERROR;
                    state_q <= EXCHANGE_IDLE_STATE;
                end
                // RULE_07: REQ discarded here
            end
            default: begin
                state_q <= EXCHANGE_IDLE_STATE;
            end
        endcase
    end
end

endmodule // psof_exchange

// ===== hdl/psof_timer.v
// Purpose: Retry timer with expiry counter for one command timer
// Assumes: start restarts the count, stop clears it
// Notes: expire pulses one cycle when the count runs out
`timescale 1ns/100ps

module psof_timer #(
    parameter CNT_W = 27,
    parameter [26:0] LOAD = 27'h4C4B400
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Control
    input wire start,
    input wire stop,
    // Status
    output reg running_q,
    output reg expire_q,
    output reg expired_once_q
);

reg [CNT_W-1:0] count_q;

always @(posedge clk) begin
    if (!nrst) begin
        running_q <= 1'b0;
        expire_q <= 1'b0;
        expired_once_q <= 1'b0;
        count_q <= {CNT_W{1'b0}};
    end else begin
        expire_q <= 1'b0;
        if (stop) begin
            // RULE_23: stop clears counter
            running_q <= 1'b0;
            expired_once_q <= 1'b0;
            count_q <= {CNT_W{1'b0}};
        end else if (start) begin
            running_q <= 1'b1;
            count_q <= LOAD[CNT_W-1:0];
            if (running_q && count_q == {{(CNT_W-1){1'b0}}, 1'b1})
                expire_q <= 1'b1;
            // RULE_23: first retransmission sets counter
            if (expire_q)
                expired_once_q <= 1'b1;
        end else if (running_q) begin
            if (count_q == {{(CNT_W-1){1'b0}}, 1'b1}) begin
                running_q <= 1'b0;
                expire_q <= 1'b1;
            end
            count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
end

endmodule // psof_timer

// ===== sim/psof_access_model.sv
// Purpose: Access-side peer model for the switch-over engine
// Assumes: Commands arrive as one-cycle strobes
// Notes: mode 0 acknowledges, 1 rejects, 2 stays silent
`timescale 1ns/100ps
`include "psof_defines.vh"
module psof_access_model (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Bench control
    input wire [1:0] mode,
    input wire [3:0] dly,
    input wire req_go,
    // Link
    input wire tx_valid,
    input wire [2:0] tx_type,
    output reg rx_valid_q,
    output reg [2:0] rx_type_q
);
    reg [3:0] cnt_q;
    reg pend_q;
    // Type lines wander while no message is sent
    always @(posedge clk) begin
        rx_valid_q <= 1'b0;
        rx_type_q <= ~rx_type_q;
        if (!nrst) begin
            pend_q <= 1'b0;
            rx_type_q <= 3'h0;
        end else if (tx_valid && (tx_type == `PSOF_MSG_COM || tx_type == `PSOF_MSG_OS_COM) && mode != 2'h2) begin
            pend_q <= 1'b1;
            cnt_q <= dly;
        end else if (pend_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
        end else if (pend_q) begin
            pend_q <= 1'b0;
            rx_valid_q <= 1'b1;
            rx_type_q <= mode == 2'h0 ? `PSOF_MSG_ACK : `PSOF_MSG_REJECT;
        end else if (req_go) begin
            rx_valid_q <= 1'b1;
            rx_type_q <= `PSOF_MSG_REQ;
        end
    end
endmodule // psof_access_model

// ===== sim/psof_exchange_props.sv
// Purpose: Port checker for the exchange switch-over engine
// Assumes: One clock, nrst synchronous active low
// Notes: Bound to every psof_exchange instance
`timescale 1ns/100ps
`include "psof_defines.vh"
module psof_exchange_props #(
    parameter LCH_W = 16,
    parameter PCH_W = 13,
    parameter [26:0] STD_TIMER_CYC = 27'h14,
    parameter [26:0] OS_TIMER_CYC = 27'h14
) (
    // Clock and reset
    input wire clk,
    input wire nrst,
    // Management
    input wire mgmt_os_com,
    input wire mgmt_com,
    input wire mgmt_reject,
    input wire [1:0] mgmt_group,
    input wire [LCH_W-1:0] mgmt_lch,
    input wire [PCH_W-1:0] mgmt_pch,
    input wire ind_valid_q,
    input wire [2:0] ind_code_q,
    input wire [2:0] state_q,
    // Link
    input wire rx_valid,
    input wire [2:0] rx_type,
    input wire tx_valid_q,
    input wire [2:0] tx_type_q,
    input wire [LCH_W-1:0] tx_lch_q,
    input wire [PCH_W-1:0] tx_pch_q
);
// ----------------
// Checks
// ----------------
    localparam [27:0] LIM = (STD_TIMER_CYC > OS_TIMER_CYC ? STD_TIMER_CYC : OS_TIMER_CYC) + 28'h8;
    wire idle = state_q == 3'h1;
    wire init = state_q == 3'h2;
    wire no_mg = !mgmt_os_com && !mgmt_com && !mgmt_reject;
    reg [27:0] quiet_q;
    // Cycles in the initiated state since the last send
    always @(posedge clk) begin
        if (!nrst || !init || tx_valid_q) begin
            quiet_q <= 28'h0;
        end else begin
            quiet_q <= quiet_q + 28'h1;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_os_cmd_sent: assert property (mgmt_os_com && mgmt_group == `PSOF_OS_GROUP && !init
        |=> tx_valid_q && tx_type_q == `PSOF_MSG_OS_COM && init && tx_lch_q == $past(mgmt_lch)
        && tx_pch_q == $past(mgmt_pch)) else $error("operator command not sent");
    a_group_refused: assert property (mgmt_os_com && mgmt_group != `PSOF_OS_GROUP && !init
        |=> !tx_valid_q && ind_valid_q && ind_code_q == `PSOF_IND_REFUSED) else $error("wrong group taken");
    a_init_ack: assert property (init && rx_valid && rx_type == `PSOF_MSG_ACK
        |=> ind_valid_q && ind_code_q == `PSOF_IND_ACK && idle) else $error("ack not handled");
    a_init_reject: assert property (init && rx_valid && rx_type == `PSOF_MSG_REJECT
        |=> ind_valid_q && ind_code_q == `PSOF_IND_REJECT && idle) else $error("reject not handled");
    a_req_ignored: assert property (init && rx_valid && rx_type == `PSOF_MSG_REQ
        |=> init && !ind_valid_q) else $error("request not discarded");
    a_idle_answer: assert property (idle && no_mg && rx_valid && rx_type inside {3'h4, 3'h5}
        |=> ind_valid_q && idle && ind_code_q == ($past(rx_type) == `PSOF_MSG_ACK ? 3'h2 : 3'h3))
        else $error("idle answer not passed");
    a_peer_req: assert property (idle && no_mg && rx_valid && rx_type == `PSOF_MSG_REQ
        |=> ind_valid_q && ind_code_q == `PSOF_IND_REQ && state_q == 3'h4) else $error("request not passed");
    a_grant_com: assert property (state_q == 3'h4 && mgmt_com && !mgmt_os_com
        |=> tx_valid_q && tx_type_q == `PSOF_MSG_COM && init) else $error("grant not sent");
    a_retry_bound: assert property (quiet_q <= LIM) else $error("no retry or exit");
    a_idle_quiet: assert property (idle && no_mg && !rx_valid
        |=> !tx_valid_q && !ind_valid_q && idle) else $error("idle not quiet");
    c_retry: cover property (init && tx_valid_q && $past(init));
    c_error: cover property (ind_valid_q && ind_code_q == `PSOF_IND_ERROR);
    c_grant: cover property (state_q == 3'h4 && mgmt_com);
endmodule // psof_exchange_props

bind psof_exchange psof_exchange_props #(.LCH_W(LCH_W), .PCH_W(PCH_W), .STD_TIMER_CYC(STD_TIMER_CYC),
    .OS_TIMER_CYC(OS_TIMER_CYC)) i_psof_exchange_props (.clk(clk), .nrst(nrst), .mgmt_os_com(mgmt_os_com),
    .mgmt_com(mgmt_com), .mgmt_reject(mgmt_reject), .mgmt_group(mgmt_group), .mgmt_lch(mgmt_lch),
    .mgmt_pch(mgmt_pch), .ind_valid_q(ind_valid_q), .ind_code_q(ind_code_q), .state_q(state_q),
    .rx_valid(rx_valid), .rx_type(rx_type), .tx_valid_q(tx_valid_q), .tx_type_q(tx_type_q),
    .tx_lch_q(tx_lch_q), .tx_pch_q(tx_pch_q));

// ===== sim/tb.sv
// Purpose: Self-checking bench for the exchange switch-over engine
// Assumes: Both command timers shortened to 20 cycles
// Notes: Peer model answers commands; bench injects stray messages
`timescale 1ns/100ps
`include "psof_defines.vh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module tb;
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg mg_os = 1'b0, mg_com = 1'b0, mg_rej = 1'b0, trv = 1'b0, req_go = 1'b0;
    reg [1:0] grp = 2'h0, mode = 2'h0;
    reg [15:0] lch = 16'h0;
    reg [12:0] pch = 13'h0;
    reg [2:0] trt = 3'h0;
    wire mrv, ind_v, tx_v;
    wire [2:0] mrt, ind_c, st, tx_t;
    wire [15:0] tx_l;
    wire [12:0] tx_p;
    int n_errors = 0;
    int checked = 0;
    initial forever #10 clk = ~clk;
    psof_exchange #(.STD_TIMER_CYC(27'h14), .OS_TIMER_CYC(27'h14)) i_psof_exchange (.clk(clk), .nrst(nrst),
        .mgmt_os_com(mg_os), .mgmt_com(mg_com), .mgmt_reject(mg_rej), .mgmt_group(grp), .mgmt_lch(lch),
        .mgmt_pch(pch), .ind_valid_q(ind_v), .ind_code_q(ind_c), .state_q(st), .rx_valid(trv | mrv),
        .rx_type(trv ? trt : mrt), .tx_valid_q(tx_v), .tx_type_q(tx_t), .tx_lch_q(tx_l), .tx_pch_q(tx_p));
    psof_access_model i_psof_access_model (.clk(clk), .nrst(nrst), .mode(mode), .dly(4'h3), .req_go(req_go),
        .tx_valid(tx_v), .tx_type(tx_t), .rx_valid_q(mrv), .rx_type_q(mrt));
// ----------------
// Tasks
// ----------------
    task report_and_stop;
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task mg(input [2:0] w, input [1:0] g);
        @(posedge clk) #1;
        {mg_rej, mg_com, mg_os} = w;
        grp = g;
        lch = lch + 16'h1111;
        pch = pch + 13'h0A5;
        @(posedge clk) #1;
        {mg_rej, mg_com, mg_os} = 3'h0;
    endtask
    task rx(input [2:0] t, input bit by_model);
        @(posedge clk) #1;
        if (by_model) req_go = 1'b1; else trv = 1'b1;
        trt = t;
        @(posedge clk) #1;
        trv = 1'b0;
        req_go = 1'b0;
        trt = ~t;
    endtask
    task automatic ev(input bit ind, input [2:0] code, input [2:0] s);
        int i;
        for (i = 0; i < 100; i++) begin
            if ((ind ? ind_v : tx_v) === 1'b1) break;
            @(posedge clk) #1;
        end
        if (i == 100) begin
            n_errors++;
            report_and_stop;
        end
        `CHK("code", code, ind ? ind_c : tx_t)
        `CHK("state", s, st)
        @(posedge clk) #1;
    endtask
    task t_os;
        mode = 2'h0;
        mg(3'h1, 2'h2);
        `CHK("lch", lch, tx_l)
        `CHK("pch", pch, tx_p)
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        ev(1, `PSOF_IND_ACK, 3'h1);
        mode = 2'h1;
        mg(3'h1, 2'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        ev(1, `PSOF_IND_REJECT, 3'h1);
        mg(3'h1, 2'h1);
        `CHK("tx", 1'b0, tx_v)
        ev(1, `PSOF_IND_REFUSED, 3'h1);
        rx(`PSOF_MSG_ACK, 0);
        ev(1, `PSOF_IND_ACK, 3'h1);
        rx(`PSOF_MSG_REJECT, 0);
        ev(1, `PSOF_IND_REJECT, 3'h1);
    endtask
    task t_peer;
        mode = 2'h0;
        rx(`PSOF_MSG_REQ, 1);
        ev(1, `PSOF_IND_REQ, 3'h4);
        mg(3'h2, 2'h0);
        ev(0, `PSOF_MSG_COM, 3'h2);
        ev(1, `PSOF_IND_ACK, 3'h1);
        rx(`PSOF_MSG_REQ, 1);
        ev(1, `PSOF_IND_REQ, 3'h4);
        mg(3'h4, 2'h0);
        ev(0, `PSOF_MSG_REJECT, 3'h1);
        rx(`PSOF_MSG_REQ, 1);
        ev(1, `PSOF_IND_REQ, 3'h4);
        mg(3'h1, 2'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        ev(1, `PSOF_IND_ACK, 3'h1);
    endtask
    task automatic t_retry;
        bit q;
        q = 1'b0;
        mode = 2'h2;
        mg(3'h1, 2'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        rx(`PSOF_MSG_REQ, 0);
        `CHK("ind", 1'b0, ind_v)
        `CHK("state", 3'h2, st)
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        `CHK("lch", lch, tx_l)
        rx(`PSOF_MSG_ACK, 0);
        ev(1, `PSOF_IND_ACK, 3'h1);
        mg(3'h1, 2'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        ev(1, `PSOF_IND_ERROR, 3'h1);
        repeat (40) begin
            q = q | (tx_v !== 1'b0) | (ind_v !== 1'b0);
            @(posedge clk) #1;
        end
        `CHK("quiet", 1'b0, q)
    endtask
    task automatic t_reset;
        bit q;
        q = 1'b0;
        mode = 2'h2;
        mg(3'h1, 2'h2);
        ev(0, `PSOF_MSG_OS_COM, 3'h2);
        nrst = 1'b0;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        `CHK("state", 3'h1, st)
        repeat (45) begin
            q = q | (tx_v !== 1'b0) | (ind_v !== 1'b0);
            @(posedge clk) #1;
        end
        `CHK("quiet", 1'b0, q)
    endtask
    initial begin
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        t_os;
        t_peer;
        t_retry;
        t_reset;
        report_and_stop;
    end
endmodule // tb
